// >>> logic/tks_ctrl.sv
// Touch-key scan control: registers, conversion sequencer, interrupt
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module tks_ctrl (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             touch_power_down_o,
  output logic [4:0]       touch_channel_select_o,
  output logic             touch_internal_ref_o,
  output logic             touch_osc_run_o,
  output logic             irq_o
);
  typedef struct packed {
    logic [7:0]         ref_low;
    logic [7:0]         ctrl_two;
    logic [7:0]         aux_one;
    logic [7:0]         touch_ctrl;
    logic [13:0]        result;
    logic [13:0]        count;
    logic [11:0]        ref_cnt;
    logic [7:0]         delay;
    logic               irq_stat;
    logic               irq_mask;
    tks_pkg::tks_state_t st;
    logic [31:0]        rdata;
  } tks_st_t;
  tks_st_t    s_q;
  tks_st_t    s_d;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       tick;
  logic [7:0] wdat;

  // ======================================================================================
  // Bus front end
  // The front end slices the word index out of the byte address itself
  tks_wb u_wb (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .cyc_i     (wb_cyc_i),
    .stb_i     (wb_stb_i),
    .we_i      (wb_we_i),
    .sel_i     (wb_sel_i[0]),
    .adr_i     (wb_adr_i[9:0]),
    .ack_o     (wb_ack_o),
    .wr_o      (wr),
    .rd_o      (rd),
    .idx_o     (idx)
  );

  // ======================================================================================
  // Oscillator, running only during the counting phase
  tks_osc u_osc (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .run_i     (s_q.st == tks_pkg::TKS_COUNT),
    .range_i   (s_q.ctrl_two[tks_pkg::BIT_RANGE]),
    .hop_i     (s_q.ctrl_two[tks_pkg::BIT_HOP]),
    .tune_i    (s_q.ctrl_two[5:4]),
    .tick_o    (tick)
  );

  assign wdat = wb_dat_i[7:0];

  // Register read mux
  function automatic logic [7:0] rd_mux(input tks_st_t s, input logic [7:0] i);
    case (i)
      tks_pkg::REG_REF_LOW:    rd_mux = s.ref_low;
      tks_pkg::REG_CTRL_TWO:   rd_mux = s.ctrl_two;
      tks_pkg::REG_AUX_ONE:    rd_mux = s.aux_one;
      tks_pkg::REG_TOUCH_CTRL: rd_mux = s.touch_ctrl;
      tks_pkg::REG_RES_LOW:    rd_mux = s.result[7:0];
      tks_pkg::REG_RES_HIGH:   rd_mux = {2'h0, s.result[13:8]};
      tks_pkg::REG_IRQ_STAT:   rd_mux = {7'h0, s.irq_stat};
      tks_pkg::REG_IRQ_MASK:   rd_mux = {7'h0, s.irq_mask};
      default:                 rd_mux = 8'h00;
    endcase
  endfunction

  // ======================================================================================
  // Next-state logic
  always_comb begin
    logic start_wr;
    logic finish;
    start_wr = 1'b0;
    finish   = 1'b0;
    s_d = s_q;
    if (rd) begin
      s_d.rdata = {24'h0, rd_mux(s_q, idx)};
    end
    if (wr && idx == tks_pkg::REG_REF_LOW) begin
      s_d.ref_low = wdat;
    end
    if (wr && idx == tks_pkg::REG_CTRL_TWO) begin
      s_d.ctrl_two = wdat;
    end
    if (wr && idx == tks_pkg::REG_TOUCH_CTRL) begin
      s_d.touch_ctrl = {wdat[7], s_q.touch_ctrl[tks_pkg::BIT_DONE], wdat[5:0]};
    end
    if (wr && idx == tks_pkg::REG_IRQ_MASK) begin
      s_d.irq_mask = wdat[0];
    end
    if (wr && idx == tks_pkg::REG_AUX_ONE) begin
      s_d.aux_one = wdat;
      start_wr    = wdat[tks_pkg::BIT_START];
    end
    if (wr && idx == tks_pkg::REG_IRQ_STAT && wdat[tks_pkg::BIT_IRQ_DONE]) begin
      s_d.irq_stat = 1'b0;
    end
    // Sequencer
    case (s_q.st)
      tks_pkg::TKS_IDLE, tks_pkg::TKS_DONE: begin
        if (start_wr && !s_q.touch_ctrl[tks_pkg::BIT_PWRDN]) begin
          s_d.st    = tks_pkg::TKS_DELAY;
          s_d.delay = 8'h0;
          s_d.touch_ctrl[tks_pkg::BIT_DONE] = 1'b0;
          s_d.irq_stat = 1'b0;
        end
      end
      tks_pkg::TKS_DELAY: begin
        if (s_q.delay == 8'(tks_pkg::START_DELAY_CYC - 1)) begin
          s_d.st      = tks_pkg::TKS_COUNT;
          s_d.count   = 14'h0;
          s_d.ref_cnt = 12'h0;
        end else begin
          s_d.delay = s_q.delay + 8'h1;
        end
      end
      tks_pkg::TKS_COUNT: begin
        s_d.count = s_q.count + 14'h1;
        if (tick) begin
          s_d.ref_cnt = s_q.ref_cnt + 12'h1;
          if (s_q.ref_cnt + 12'h1 == {s_q.ctrl_two[3:0], s_q.ref_low}) begin
            finish = 1'b1;
          end
        end
        if (finish) begin
          s_d.st     = tks_pkg::TKS_DONE;
          s_d.result = s_q.count + 14'h1;
        end
      end
      default: begin
        s_d.st = tks_pkg::TKS_IDLE;
      end
    endcase
    // Aborted by software zero or power-down; a power-down write stops the
    // scan at the same edge, so the pins never see a running oscillator while off
    if ((s_q.st == tks_pkg::TKS_DELAY || s_q.st == tks_pkg::TKS_COUNT) &&
        ((wr && idx == tks_pkg::REG_AUX_ONE && !wdat[tks_pkg::BIT_START]) ||
         (wr && idx == tks_pkg::REG_TOUCH_CTRL && wdat[tks_pkg::BIT_PWRDN]) ||
         s_q.touch_ctrl[tks_pkg::BIT_PWRDN])) begin
      s_d.st = tks_pkg::TKS_IDLE;
      finish = 1'b0;
    end
    if (finish) begin
      s_d.aux_one[tks_pkg::BIT_START]   = 1'b0;
      s_d.touch_ctrl[tks_pkg::BIT_DONE] = 1'b1;
      s_d.irq_stat = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q.ref_low    <= tks_pkg::RST_REF_LOW;
      s_q.ctrl_two   <= tks_pkg::RST_CTRL_TWO;
      s_q.aux_one    <= tks_pkg::RST_AUX_ONE;
      s_q.touch_ctrl <= tks_pkg::RST_TOUCH_CTRL;
      s_q.result     <= 14'h0;
      s_q.count      <= 14'h0;
      s_q.ref_cnt    <= 12'h0;
      s_q.delay      <= 8'h0;
      s_q.irq_stat   <= 1'b0;
      s_q.irq_mask   <= 1'b0;
      s_q.st         <= tks_pkg::TKS_IDLE;
      s_q.rdata      <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign wb_dat_o               = s_q.rdata;
  assign touch_power_down_o     = s_q.touch_ctrl[tks_pkg::BIT_PWRDN];
  assign touch_channel_select_o = s_q.touch_ctrl[4:0];
  assign touch_internal_ref_o   = s_q.touch_ctrl[4:0] == tks_pkg::CH_INTERNAL;
  assign touch_osc_run_o        = s_q.st == tks_pkg::TKS_COUNT;
  assign irq_o                  = s_q.irq_stat && s_q.irq_mask;

  // ======================================================================================
  // Checks
  // start leads to delay
  property p_start;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wr && idx == tks_pkg::REG_AUX_ONE && wdat[5] && !s_q.touch_ctrl[7] &&
       (s_q.st == tks_pkg::TKS_IDLE || s_q.st == tks_pkg::TKS_DONE))
      |=> (s_q.st == tks_pkg::TKS_DELAY && !s_q.touch_ctrl[6]);
  endproperty
  a_start: assert property (p_start) else $error("start did not begin conversion");
  property p_hwclr;
    @(posedge ref_clk_i) disable iff (srst_i)
      $rose(s_q.touch_ctrl[6]) |-> !s_q.aux_one[5];
  endproperty
  a_hwclr: assert property (p_hwclr) else $error("start bit not cleared at end");
  property p_swclr;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wr && idx == tks_pkg::REG_AUX_ONE && !wdat[5]) |=> !s_q.aux_one[5];
  endproperty
  a_swclr: assert property (p_swclr) else $error("software clear lost");
  property p_reflow;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wr && idx == tks_pkg::REG_REF_LOW) |=> s_q.ref_low == $past(wdat);
  endproperty
  a_reflow: assert property (p_reflow) else $error("reference low not stored");
  property p_target;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st == tks_pkg::TKS_COUNT ##1 s_q.st == tks_pkg::TKS_DONE)
      |-> s_q.ref_cnt == {s_q.ctrl_two[3:0], s_q.ref_low};
  endproperty
  a_target: assert property (p_target) else $error("ended off target");
  property p_intref;
    @(posedge ref_clk_i) disable iff (srst_i)
      touch_internal_ref_o |-> touch_channel_select_o == 5'h0f;
  endproperty
  a_intref: assert property (p_intref) else $error("internal ref wrong");
  property p_done;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st == tks_pkg::TKS_COUNT) |-> !s_q.touch_ctrl[6];
  endproperty
  a_done: assert property (p_done) else $error("done high in conversion");
  property p_pwrdn;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.touch_ctrl[7] && s_q.st != tks_pkg::TKS_COUNT) |=> s_q.st != tks_pkg::TKS_DELAY;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("started while powered down");

  // ======================================================================================
  // Bus handshake and sequencer timing
  // request is answered
  property p_ack_req;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("bus request not answered");
  property p_ack_pulse;
    @(posedge ref_clk_i) disable iff (srst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_rd_upper;
    @(posedge ref_clk_i) disable iff (srst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_chan_wr;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wr && idx == tks_pkg::REG_TOUCH_CTRL) |=> touch_channel_select_o == $past(wdat[4:0]);
  endproperty
  a_chan_wr: assert property (p_chan_wr) else $error("channel not stored");
  property p_start_clr;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st != tks_pkg::TKS_DELAY ##1 s_q.st == tks_pkg::TKS_DELAY)
      |-> !s_q.irq_stat && !s_q.touch_ctrl[tks_pkg::BIT_DONE];
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start left old flags");
  property p_delay_len;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st == tks_pkg::TKS_DELAY ##1 s_q.st == tks_pkg::TKS_COUNT)
      |-> $past(s_q.delay) == 8'(tks_pkg::START_DELAY_CYC - 1);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("start delay wrong length");
  property p_count_clr;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st == tks_pkg::TKS_DELAY ##1 s_q.st == tks_pkg::TKS_COUNT)
      |-> s_q.count == 14'h0 && s_q.ref_cnt == 12'h0;
  endproperty
  a_count_clr: assert property (p_count_clr) else $error("counters not cleared");
  property p_tick_run;
    @(posedge ref_clk_i) disable iff (srst_i)
      tick |-> $past(touch_osc_run_o);
  endproperty
  a_tick_run: assert property (p_tick_run) else $error("tick while stopped");
  property p_fin_flags;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st == tks_pkg::TKS_COUNT ##1 s_q.st == tks_pkg::TKS_DONE)
      |-> s_q.touch_ctrl[tks_pkg::BIT_DONE] && s_q.irq_stat &&
          !s_q.aux_one[tks_pkg::BIT_START];
  endproperty
  a_fin_flags: assert property (p_fin_flags) else $error("finish flags wrong");
  property p_done_hold;
    @(posedge ref_clk_i) disable iff (srst_i)
      (s_q.st == tks_pkg::TKS_DONE && !wr)
      |=> s_q.st == tks_pkg::TKS_DONE && s_q.touch_ctrl[tks_pkg::BIT_DONE];
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost");
  property p_irq_clr;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wr && idx == tks_pkg::REG_IRQ_STAT && wdat[0] && s_q.st != tks_pkg::TKS_COUNT)
      |=> !s_q.irq_stat && !irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("status not cleared");
  property p_abort;
    @(posedge ref_clk_i) disable iff (srst_i)
      (wr && idx == tks_pkg::REG_AUX_ONE && !wdat[5] &&
       (s_q.st == tks_pkg::TKS_DELAY || s_q.st == tks_pkg::TKS_COUNT))
      |=> s_q.st == tks_pkg::TKS_IDLE && !s_q.touch_ctrl[tks_pkg::BIT_DONE];
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not stopped");
  property p_pd_idle;
    @(posedge ref_clk_i) disable iff (srst_i)
      touch_power_down_o |-> s_q.st == tks_pkg::TKS_IDLE || s_q.st == tks_pkg::TKS_DONE;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("converting while powered down");
endmodule

// >>> logic/tks_pkg.sv
// Package with register map, fields, reset values and timing for the touch-key scan control
// ==========================================================================================
// Function
// - Writing one to the start bit begins a new touch-key conversion.
// - Hardware clears the start bit when the conversion finishes.
// - Software may also clear the start bit by writing zero.
// - Reference count bits 7..0 are a read/write register, reset to all ones.
// - Reference count bits 11..8 sit in the low nibble of control two.
// - Control two bit 6 selects slow (0) or fast (1) oscillator range.
// - Channel code 15 connects the internal reference capacitor, not an external key.
// - Done flag reads zero while converting, one when finished; 14-bit result kept.
package tks_pkg;
  // ========================================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] REG_REF_LOW    = 8'hb4;
  localparam logic [7:0] REG_CTRL_TWO   = 8'hb5;
  localparam logic [7:0] REG_AUX_ONE    = 8'hf8;
  localparam logic [7:0] REG_TOUCH_CTRL = 8'hae;
  localparam logic [7:0] REG_RES_LOW    = 8'hac;
  localparam logic [7:0] REG_RES_HIGH   = 8'hb7;
  localparam logic [7:0] REG_IRQ_STAT   = 8'hc0;
  localparam logic [7:0] REG_IRQ_MASK   = 8'hc1;
  // ========================================================================================
  // Field positions
  localparam int BIT_START     = 5;
  localparam int BIT_HOP       = 7;
  localparam int BIT_RANGE     = 6;
  localparam int BIT_PWRDN     = 7;
  localparam int BIT_DONE      = 6;
  localparam int BIT_IRQ_DONE  = 0;
  // ========================================================================================
  // Reset values
  localparam logic [7:0] RST_REF_LOW    = 8'hff;
  localparam logic [7:0] RST_CTRL_TWO   = 8'h00;
  localparam logic [7:0] RST_AUX_ONE    = 8'h00;
  localparam logic [7:0] RST_TOUCH_CTRL = 8'h8f;
  localparam logic [4:0] CH_INTERNAL    = 5'h0f;
  // ========================================================================================
  // Timing: delay before done may rise, and oscillator divider periods
  localparam int START_DELAY_NS = 3000;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DIV_SLOW_BASE = 4'h8;
  localparam logic [3:0] DIV_FAST_BASE = 4'h4;
  typedef enum logic [1:0] {
    TKS_IDLE  = 2'b00,
    TKS_DELAY = 2'b01,
    TKS_COUNT = 2'b10,
    TKS_DONE  = 2'b11
  } tks_state_t;
endpackage

// >>> logic/tks_osc.sv
// Touch oscillator model: emits one enable pulse per oscillator period
`timescale 1ns/1ps
module tks_osc (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       run_i,
  input  wire logic       range_i,
  input  wire logic       hop_i,
  input  wire logic [1:0] tune_i,
  output logic            tick_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic [1:0] hop;
    logic       tick;
  } tks_osc_st_t;
  tks_osc_st_t s_q;
  tks_osc_st_t s_d;
  logic [3:0]  period;

  // ======================================================================================
  // Period selection
  always_comb begin
    logic [1:0] step;
    step = 2'h0;
    period = range_i ? tks_pkg::DIV_FAST_BASE : tks_pkg::DIV_SLOW_BASE;
    step = hop_i ? s_q.hop : tune_i;
    period = period - {2'h0, step};
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run_i) begin
      s_d.cnt = 4'h0;
    end else if (s_q.cnt >= period) begin
      s_d.cnt  = 4'h0;
      s_d.tick = 1'b1;
      s_d.hop  = s_q.hop + 2'h1;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule

// >>> logic/tks_wb.sv
// Classic Wishbone slave front end: decode and one-cycle ack
`timescale 1ns/1ps
module tks_wb (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic       sel_i,
  input  wire logic [9:0] adr_i,
  output logic            ack_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      idx_o
);
  typedef struct packed {
    logic ack;
  } tks_wb_st_t;
  tks_wb_st_t s_q;
  tks_wb_st_t s_d;
  logic       req;

  // Request pending and not yet answered
  always_comb begin
    req = cyc_i && stb_i && !s_q.ack;
    s_d = s_q;
    s_d.ack = req;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o = s_q.ack;
  assign wr_o  = req && we_i && sel_i;
  assign rd_o  = req && !we_i;
  assign idx_o = adr_i[9:2];
endmodule

// >>> tb/tks_keys.sv
// Electrode-side model: follows the connected key and flags misuse of the pins
`timescale 1ns/1ps
module tks_keys (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       power_down_i,
  input  wire logic [4:0] channel_i,
  input  wire logic       internal_ref_i,
  input  wire logic       osc_run_i,
  output logic            fault_o,
  output int              run_cycles_o
);
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      fault_o      <= 1'b0;
      run_cycles_o <= 0;
    end else begin
      if (internal_ref_i !== (channel_i == 5'h0f)) fault_o <= 1'b1;
      if (osc_run_i === 1'b1 && power_down_i !== 1'b0) fault_o <= 1'b1;
      if (osc_run_i === 1'b1) run_cycles_o <= run_cycles_o + 1;
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the touch-key scan control registers and sequencer
`timescale 1ns/1ps
module tb_top;
  // ==================================================================
  // Stimulus, observed outputs and register model
  logic        ref_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [11:0] wb_adr_i  = 12'h000;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pwr_dn;
  logic [4:0]  chan;
  logic        int_ref;
  logic        osc_run;
  logic        irq;
  logic        key_fault;
  int          key_runs;
  int          failures = 0;
  int          n_checks = 0;
  logic [7:0]  mdl [0:255];
  logic [31:0] rd;
  logic [7:0]  cfg [0:3] = '{8'h00, 8'h40, 8'h30, 8'h80};
  logic [3:0]  sel_v     = 4'h1;
  int          hops      = 0;
  int          ex;
  // Free-running system clock
  always #12.5 ref_clk_i = ~ref_clk_i;
  tks_ctrl i_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .touch_power_down_o(pwr_dn),
    .touch_channel_select_o(chan), .touch_internal_ref_o(int_ref),
    .touch_osc_run_o(osc_run), .irq_o(irq));
  tks_keys i_keys (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .power_down_i(pwr_dn), .channel_i(chan),
    .internal_ref_i(int_ref), .osc_run_i(osc_run), .fault_o(key_fault),
    .run_cycles_o(key_runs));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1);
    chk(32'(k), 32'h2);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  // Write that also updates the model; done flag is read-only
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
    mdl[idx] = (idx == 8'hae) ? {wd[7], mdl[idx][6], wd[5:0]} : wd;
  endtask
  task automatic rdchk(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, mdl[idx]});
  endtask
  // Expected count: one more than the system cycles up to the n-th oscillator tick
  function automatic int exp_res(input logic [7:0] c2, input int h0, input int n);
    int r;
    int stp;
    r = 1;
    for (int t = 0; t < n; t++) begin
      stp = c2[7] ? (h0 + t) % 4 : int'(c2[5:4]);
      r += (c2[6] ? int'(tks_pkg::DIV_FAST_BASE) : int'(tks_pkg::DIV_SLOW_BASE)) - stp + 1;
    end
    return r;
  endfunction
  // Watchdog
  initial begin
    #(25 * 40000);
    failures++;
    give_verdict();
  end
  // ==================================================================
  // Main sequence
  initial begin
    int i;
    foreach (mdl[j]) mdl[j] = 8'h00;
    mdl[8'hb4] = 8'hff;
    mdl[8'hae] = 8'h8f;
    void'($urandom(36));
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    chk({27'h0, chan}, 32'hf);
    chk({31'h0, int_ref}, 32'h1);
    chk({31'h0, pwr_dn}, 32'h1);
    rdchk(8'hb4);
    rdchk(8'hb5);
    rdchk(8'hf8);
    rdchk(8'hae);
    bus(1'b1, 8'h10, 8'h5a);
    rdchk(8'h10);
    sel_v = 4'h0;
    bus(1'b1, 8'hb4, 8'h3c);
    sel_v = 4'h1;
    rdchk(8'hb4);
    repeat (4) begin
      wr(8'hb5, 8'($urandom));
      rdchk(8'hb5);
      wr(8'hb4, 8'($urandom));
      rdchk(8'hb4);
    end
    for (i = 0; i < 20; i++) begin
      wr(8'hae, {3'b000, 5'(i)});
      chk({27'h0, chan}, 32'(i));
      chk({31'h0, int_ref}, {31'h0, i == 15});
      chk({31'h0, pwr_dn}, 32'h0);
    end
    wr(8'hae, 8'h0f);
    wr(8'hc1, 8'h01);
    wr(8'hb4, 8'h04);
    for (i = 0; i < 4; i++) begin
      wr(8'hb5, cfg[i]);
      wr(8'hf8, 8'h20);
      mdl[8'hae][6] = 1'b0;
      rdchk(8'hf8);
      rdchk(8'hae);
      repeat (400) begin
        bus(1'b0, 8'hae, 8'h00);
        if (rd[6] === 1'b1) break;
      end
      mdl[8'hae][6] = 1'b1;
      mdl[8'hf8] = 8'h00;
      mdl[8'hc0] = 8'h01;
      rdchk(8'hf8);
      rdchk(8'hae);
      rdchk(8'hc0);
      ex = exp_res(cfg[i], hops, 4);
      hops += 4;
      bus(1'b0, 8'hac, 8'h00);
      chk(rd, 32'(ex) & 32'hff);
      bus(1'b0, 8'hb7, 8'h00);
      chk(rd, 32'(ex) >> 8);
      chk({31'h0, irq}, 32'h1);
      wr(8'hc1, 8'h00);
      chk({31'h0, irq}, 32'h0);
      wr(8'hc1, 8'h01);
      bus(1'b1, 8'hc0, 8'h01);
      mdl[8'hc0] = 8'h00;
      chk({31'h0, irq}, 32'h0);
    end
    chk({31'h0, key_runs > 0}, 32'h1);
    wr(8'hf8, 8'h20);
    wr(8'hf8, 8'h00);
    mdl[8'hae][6] = 1'b0;
    repeat (60) rdchk(8'hae);
    rdchk(8'hf8);
    chk({31'h0, osc_run}, 32'h0);
    wr(8'hf8, 8'h20);
    repeat (130) @(posedge ref_clk_i);
    chk({31'h0, osc_run}, 32'h1);
    wr(8'hae, 8'h8f);
    rdchk(8'hae);
    chk({31'h0, osc_run}, 32'h0);
    wr(8'hf8, 8'h20);
    repeat (130) @(posedge ref_clk_i);
    rdchk(8'hae);
    chk({31'h0, osc_run}, 32'h0);
    chk({31'h0, key_fault}, 32'h0);
    give_verdict();
  end
endmodule
